/* isz_exec.v */
// Execution of the two increment-and-skip-if-zero instructions.
// Assumes decode gives a one-cycle start pulse and memory read data
// is valid in the same cycle as the read strobe.
// Pulses last one cycle; address, data and accumulator hold.
`include "isz_defs.vh"

module isz_exec (
   // Clock and reset
   input wire clk_in,
   input wire nrst_in,
   // From decode
   input wire start_mem_in,
   input wire increment_skip_zero_to_accumulator_in,
   input wire [7:0] addr_in,
   // Data memory
   input wire [7:0] mem_rdata_in,
   output reg mem_rd_out,
   output reg mem_wr_out,
   output reg [7:0] mem_addr_out,
   output reg [7:0] mem_wdata_out,
   // Accumulator
   output reg [7:0] acc_out,
   output reg acc_wr_out,
   // Pipeline control
   output wire busy_out,
   output reg skip_out,
   output reg done_out
);

   // Byte width and state codes
   localparam integer DATA_W = 8;
   localparam [1:0] ST_IDLE = `ISZ_ST_IDLE;
   localparam [1:0] ST_EXEC = `ISZ_ST_EXEC;
   localparam [1:0] ST_DUMMY = `ISZ_ST_DUMMY;

   // Current state
   reg [1:0] state;
   reg acc_mode;

   // Next values
   reg [1:0] next_state;
   reg next_acc_mode;
   reg next_mem_rd;
   reg next_mem_wr;
   reg [7:0] next_mem_addr;
   reg [7:0] next_mem_wdata;
   reg [7:0] next_acc;
   reg next_acc_wr;
   reg next_skip;
   reg next_done;

   // Incrementer and start decode
   wire [7:0] sum;
   wire [7:0] carry;
   wire start_any;
   genvar bit_idx;

   // Zero test of a result byte
   function byte_is_zero;
      input [7:0] value;
      begin
         byte_is_zero = (value == `ISZ_ZERO);
      end
   endfunction

   // Ripple incrementer; the carry out of the top bit is dropped
   assign carry[0] = 1'b1;
   generate
      for (bit_idx = 0; bit_idx < DATA_W; bit_idx = bit_idx + 1) begin : g_inc
         assign sum[bit_idx] = mem_rdata_in[bit_idx] ^ carry[bit_idx];
         if (bit_idx < DATA_W - 1) begin : g_carry
            assign carry[bit_idx + 1] = mem_rdata_in[bit_idx] & carry[bit_idx];
         end
      end
   endgenerate

   // Start strobes and busy level
   assign start_any = start_mem_in | increment_skip_zero_to_accumulator_in;
   assign busy_out = (state != ST_IDLE);

   always @* begin
      // Pulses default low; held values keep their last value
      next_state = state;
      next_acc_mode = acc_mode;
      next_mem_rd = 1'b0;
      next_mem_wr = 1'b0;
      next_mem_addr = mem_addr_out;
      next_mem_wdata = mem_wdata_out;
      next_acc = acc_out;
      next_acc_wr = 1'b0;
      next_skip = 1'b0;
      next_done = 1'b0;

      case (state)
         ST_IDLE: begin
            if (start_any) begin
               // Accumulator variant wins when both strobes are high
               next_acc_mode = increment_skip_zero_to_accumulator_in;
               next_mem_addr = addr_in;
               next_mem_rd = 1'b1;
               next_state = ST_EXEC;
            end
         end
         ST_EXEC: begin
            // Read data arrives now; write back or load the accumulator
            if (acc_mode) begin
               next_acc = sum;
               next_acc_wr = 1'b1;
            end else begin
               next_mem_wdata = sum;
               next_mem_wr = 1'b1;
            end
            // Taken skip adds the dummy cycle
            if (byte_is_zero(sum)) begin
               next_skip = 1'b1;
               next_state = ST_DUMMY;
            end
            if (!byte_is_zero(sum)) begin
               next_done = 1'b1;
               next_state = ST_IDLE;
            end
         end
         ST_DUMMY: begin
            // Dummy cycle stands in for the skipped instruction
            next_done = 1'b1;
            next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // Sequencer registers
   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Variant latched at start
   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         acc_mode <= 1'b0;
      end else begin
         acc_mode <= next_acc_mode;
      end
   end

   // Data memory port registers
   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         mem_rd_out <= 1'b0;
      end else begin
         mem_rd_out <= next_mem_rd;
      end
   end

   // Write back only for the memory variant
   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         mem_wr_out <= 1'b0;
      end else begin
         mem_wr_out <= next_mem_wr;
      end
   end

   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         mem_addr_out <= 8'h00;
      end else begin
         mem_addr_out <= next_mem_addr;
      end
   end

   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         mem_wdata_out <= 8'h00;
      end else begin
         mem_wdata_out <= next_mem_wdata;
      end
   end

   // Accumulator registers
   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         acc_out <= `ISZ_ACC_RESET;
      end else begin
         acc_out <= next_acc;
      end
   end

   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         acc_wr_out <= 1'b0;
      end else begin
         acc_wr_out <= next_acc_wr;
      end
   end

   // Skip pulse tells fetch to discard the next instruction
   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         skip_out <= 1'b0;
      end else begin
         skip_out <= next_skip;
      end
   end

   // Done pulse marks the end of the instruction
   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         done_out <= 1'b0;
      end else begin
         done_out <= next_done;
      end
   end
endmodule // isz_exec

/* isz_defs.vh */
// Constants for the increment-and-skip-if-zero execution block.
// Assumes a single core clock; included by isz_exec.v.
// Functional notes
// - Read byte, add one, memory variant writes back
// - Zero result skips the following instruction
// - Taken skip costs two cycles, dummy inserted
// - Accumulator variant writes accumulator, memory unchanged
// - Nonzero result continues with next instruction
`ifndef ISZ_DEFS_VH
`define ISZ_DEFS_VH
`define ISZ_INC_STEP 8'h01
`define ISZ_ZERO 8'h00
`define ISZ_ACC_RESET 8'h00
`define ISZ_ST_IDLE 2'h0
`define ISZ_ST_EXEC 2'h1
`define ISZ_ST_DUMMY 2'h2
`endif

/* isz_exec_properties.sv */
// isz_exec checker; sees its ports only.
module isz_chk(input wire clk_in,nrst_in,mem_rd_out,mem_wr_out,acc_wr_out,skip_out,done_out,
input wire [7:0] mem_rdata_in,mem_wdata_out,acc_out);
logic [7:0] p;
wire wb=mem_wr_out|acc_wr_out;
always @(posedge clk_in) p<=mem_rdata_in+8'h01;
default clocking @(posedge clk_in); endclocking
default disable iff (!nrst_in);
a_rd_wb: assert property (mem_rd_out|=>wb) else $error("wb");
a_mem_sum: assert property (mem_wr_out|->mem_wdata_out==p) else $error("sum");
a_skip_zero: assert property (skip_out|->wb&&p==0) else $error("skip");
a_skip_len: assert property (skip_out|=>done_out) else $error("len");
a_acc_only: assert property (acc_wr_out|->!mem_wr_out&&acc_out==p) else $error("acc");
a_go_on: assert property (wb&&p!=0|->done_out&&!skip_out) else $error("go");
cover property (skip_out);
cover property (acc_wr_out&&done_out);
cover property (mem_wr_out&&done_out);
endmodule // isz_chk
bind isz_exec isz_chk u_chk(.*);

/* tb_top.sv */
// isz_exec bench; drives its ports directly.
module tb_top;
timeunit 1ns;
timeprecision 1ns;
logic clk_in=0,nrst_in=0,m=0,a=0;
logic [7:0] r=0,ad=0;
wire w,q,s,d,rd,b;
wire [7:0] o,c,ma;
int err_count=0,total_checks=0,t=0;
isz_exec i_dut(.clk_in,.nrst_in,.start_mem_in(m),.increment_skip_zero_to_accumulator_in(a),.addr_in(ad),
.mem_rdata_in(r),.mem_rd_out(rd),.mem_wr_out(w),.mem_addr_out(ma),.mem_wdata_out(o),.acc_out(c),
.acc_wr_out(q),.busy_out(b),.skip_out(s),.done_out(d));
initial forever #4 clk_in=~clk_in;
task end_sim;
$display("%0d checks %0d errors",total_checks,err_count);
if(err_count==0&&total_checks>0) $display("Testbench passed");
else $display("Testbench failed");
$finish;
endtask
task chk(logic [7:0] g,e);
total_checks++;
if(g!==e) err_count++;
if(g!==e) $display("Error %0t bad %h",$time,g);
endtask
always @(posedge clk_in) if(++t>99) begin
chk(1,0);
end_sim;
end
task op(logic x,logic [7:0] v);
@(posedge clk_in) {m,a,ad}<={!x,x,v^8'h5a};
@(posedge clk_in) {r,ad}<={v,8'h00};
#1 chk({rd,b},2'b11);
chk(ma,v^8'h5a);
@(posedge clk_in) {m,a}<=2'b00;
#1 chk({w,q,s,d},{!x,x,v==8'hff,v!=8'hff});
chk(x?c:o,v+8'h01);
@(posedge clk_in) #1 chk({d,b,rd},{v==8'hff,2'b00});
$display("op %h done",v);
endtask
initial begin
repeat(8) @(posedge clk_in);
nrst_in<=1;
op(0,8'h41);
op(1,8'h7e);
op(0,8'hff);
op(1,8'hff);
end_sim;
end
endmodule // tb_top
